// ==== rtl/skft_decode.sv ====
// opcode decoder for the skip-on-flag test group
// assumes opcode_in is the word in its execution cycle; purely combinational
module skft_decode
  import skft_pkg::*;
(
  input wire logic [9:0] opcode_in,
  output skft_test_t test_out
);

  // ********************************************
  // decode
  // ********************************************
  function automatic skft_test_t skft_classify(input logic [9:0] op);
    skft_test_t t;
    t = SKFT_TEST_NONE;
    case (op)
      SKFT_OP_TEST_EXT_IRQ1_LEVEL: t = SKFT_TEST_EXT_IRQ1_LEVEL;
      SKFT_OP_TEST_POWER_DOWN_FLAG: t = SKFT_TEST_POWER_DOWN_FLAG;
      SKFT_OP_TEST_SERIAL_REQUEST: t = SKFT_TEST_SERIAL_REQUEST;
      SKFT_OP_TEST_TIMER1_REQUEST: t = SKFT_TEST_TIMER1_REQUEST;
      default: t = SKFT_TEST_NONE;
    endcase
    return t;
  endfunction

  always_comb
  begin
    test_out = skft_classify(opcode_in);
  end

endmodule // skft_decode

// ==== rtl/skft_pkg.sv ====
// constants and types for the skip-on-flag test unit
// assumes 10-bit instruction words and 4-bit interrupt control registers
package skft_pkg;

  // ********************************************
  // instruction encodings
  // ********************************************
  localparam logic [9:0] SKFT_OP_TEST_EXT_IRQ1_LEVEL = 10'h03b;
  localparam logic [9:0] SKFT_OP_TEST_POWER_DOWN_FLAG = 10'h003;
  localparam logic [9:0] SKFT_OP_TEST_SERIAL_REQUEST = 10'h288;
  localparam logic [9:0] SKFT_OP_TEST_TIMER1_REQUEST = 10'h280;

  // ********************************************
  // control register field positions
  // ********************************************
  localparam int SKFT_EXT_IRQ1_POLARITY_POS = 2;
  localparam int SKFT_SERIAL_IRQ_ENABLE_POS = 3;
  localparam int SKFT_TIMER1_IRQ_ENABLE_POS = 2;
  localparam int SKFT_CTRL_WIDTH = 4;

  // ********************************************
  // reset values
  // ********************************************
  localparam logic SKFT_SKIP_RESET = 1'b0;
  localparam logic SKFT_CLEAR_RESET = 1'b0;
  localparam logic SKFT_RESULT_RESET = 1'b0;

  typedef enum logic [2:0] {
    SKFT_TEST_NONE,
    SKFT_TEST_EXT_IRQ1_LEVEL,
    SKFT_TEST_POWER_DOWN_FLAG,
    SKFT_TEST_SERIAL_REQUEST,
    SKFT_TEST_TIMER1_REQUEST
  } skft_test_t;

  typedef enum {
    SKFT_ST_EXECUTE,
    SKFT_ST_DISCARD
  } skft_state_t;

endpackage : skft_pkg

// ==== rtl/skft_skip_test_unit.sv ====
// skip-on-flag test unit: executes four one-word skip tests for the core
// assumes the sequencer pulses exec_valid_in once per executed instruction
// and discards the next instruction while skip_next_out is high
// control registers and request flags are owned elsewhere; this unit only
// reads them and asks the flag owners to clear through one-cycle pulses
module skft_skip_test_unit
  import skft_pkg::*;
#(
  parameter int CTRL_WIDTH = SKFT_CTRL_WIDTH
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic exec_valid_in,
  input wire logic [9:0] opcode_in,
  input wire logic ext_irq1_pin_in,
  input wire logic [CTRL_WIDTH-1:0] ext_irq1_control_reg_in,
  input wire logic [CTRL_WIDTH-1:0] periph_irq_control_reg_a_in,
  input wire logic [CTRL_WIDTH-1:0] periph_irq_control_reg_b_in,
  input wire logic power_down_flag_in,
  input wire logic serial_request_flag_in,
  input wire logic timer1_request_flag_in,
  output logic skip_next_out,
  output logic clear_serial_request_out,
  output logic clear_timer1_request_out,
  output logic test_done_out,
  output logic test_skipped_out
);

  // ********************************************
  // decode and control bits
  // ********************************************
  skft_test_t test;
  logic ext_irq1_polarity_bit;
  logic serial_irq_enable_bit;
  logic timer1_irq_enable_bit;

  skft_decode u_decode (
    .opcode_in(opcode_in),
    .test_out(test)
  );

  // ********************************************
  // control bits
  // ********************************************
  // field positions come from the package so all three taps agree

  always_comb
  begin
    ext_irq1_polarity_bit = ext_irq1_control_reg_in[SKFT_EXT_IRQ1_POLARITY_POS];
    serial_irq_enable_bit = periph_irq_control_reg_b_in[SKFT_SERIAL_IRQ_ENABLE_POS];
    timer1_irq_enable_bit = periph_irq_control_reg_a_in[SKFT_TIMER1_IRQ_ENABLE_POS];
  end

  // ********************************************
  // skip decision
  // ********************************************
  // a level test skips when the pin matches the selected polarity
  function automatic logic skft_level_match(input logic pin, input logic polarity);
    return (pin == polarity);
  endfunction

  // a gated request test skips only with its enable low and its flag set;
  // enable high turns the test into a no-operation that leaves the flag alone
  function automatic logic skft_gated(input logic flag, input logic enable);
    return flag && !enable;
  endfunction

  // ********************************************
  // decision signals
  // ********************************************

  skft_state_t state;
  skft_state_t next_state;
  logic live;
  logic is_test;
  logic skip_now;
  logic clear_serial_now;
  logic clear_timer1_now;
  logic discard_now;

  // an instruction executed while a discard is pending has no effect at all
  // pulses and skip share one decision, so a clear never comes alone
  always_comb
  begin
    live = exec_valid_in && (state == SKFT_ST_EXECUTE);
    discard_now = exec_valid_in && (state == SKFT_ST_DISCARD);
    is_test = live && (test != SKFT_TEST_NONE);
    skip_now = 1'b0;
    clear_serial_now = 1'b0;
    clear_timer1_now = 1'b0;
    if (live)
    begin
      case (test)
        SKFT_TEST_EXT_IRQ1_LEVEL:
        begin
          // sampled this cycle, no pipelining of the pin
          skip_now = skft_level_match(ext_irq1_pin_in, ext_irq1_polarity_bit);
        end
        SKFT_TEST_POWER_DOWN_FLAG:
        begin
          // no clear strobe for this flag
          skip_now = power_down_flag_in;
        end
        SKFT_TEST_SERIAL_REQUEST:
        begin
          skip_now = skft_gated(serial_request_flag_in, serial_irq_enable_bit);
          clear_serial_now = skip_now;
        end
        SKFT_TEST_TIMER1_REQUEST:
        begin
          skip_now = skft_gated(timer1_request_flag_in, timer1_irq_enable_bit);
          clear_timer1_now = skip_now;
        end
        default:
        begin
          skip_now = 1'b0;
        end
      endcase
    end
  end

  // ********************************************
  // sequencing state
  // ********************************************
  // a skip never chains: the discarded word cannot start another skip,
  // so two states are enough
  // reset lands in the execute state, so the first word after release runs
  always_comb
  begin
    next_state = state;
    case (state)
      SKFT_ST_EXECUTE:
      begin
        if (skip_now)
        begin
          next_state = SKFT_ST_DISCARD;
        end
      end
      SKFT_ST_DISCARD:
      begin
        // the fetched word executes as nothing, then normal flow resumes
        if (discard_now)
        begin
          next_state = SKFT_ST_EXECUTE;
        end
      end
      default:
      begin
        next_state = SKFT_ST_EXECUTE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= SKFT_ST_EXECUTE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ********************************************
  // registered outputs
  // ********************************************
  // clears are registered, so the owner sees them one cycle after the
  // test; the discarded slot in between cannot re-read the stale flag
  logic next_clear_serial;
  logic next_clear_timer1;
  logic next_done;
  logic next_skipped;

  always_comb
  begin
    next_clear_serial = clear_serial_now;
    next_clear_timer1 = clear_timer1_now;
    next_done = is_test;
    next_skipped = skip_now;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      clear_serial_request_out <= SKFT_CLEAR_RESET;
      clear_timer1_request_out <= SKFT_CLEAR_RESET;
      test_done_out <= SKFT_RESULT_RESET;
      test_skipped_out <= SKFT_RESULT_RESET;
    end
    else
    begin
      clear_serial_request_out <= next_clear_serial;
      clear_timer1_request_out <= next_clear_timer1;
      test_done_out <= next_done;
      test_skipped_out <= next_skipped;
    end
  end

  // ********************************************
  // sequencer interface
  // ********************************************
  // high from the edge after a skipping test until the discarded word is seen
  always_comb
  begin
    skip_next_out = (state == SKFT_ST_DISCARD) ? 1'b1 : SKFT_SKIP_RESET;
  end

endmodule // skft_skip_test_unit

// ==== tb/skft_flag_model.sv ====
// request flag owner: set by the bench, cleared by the unit's pulses
// assumes set strobes change at the falling edge and the bench reset clears it
module skft_flag_model
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // set wins over clear, so a new request is never lost
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clear_in)
      flag_out <= 1'b0;
  end
endmodule // skft_flag_model

// ==== tb/skft_skip_test_unit_sva.sv ====
// checker for the skip test unit, bound onto its ports
// assumes one clock domain and the active-low async reset
module skft_sva
  import skft_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic exec_valid_in,
  input wire logic [9:0] opcode_in,
  input wire logic ext_irq1_pin_in,
  input wire logic [3:0] ext_irq1_control_reg_in,
  input wire logic [3:0] periph_irq_control_reg_a_in,
  input wire logic [3:0] periph_irq_control_reg_b_in,
  input wire logic power_down_flag_in,
  input wire logic serial_request_flag_in,
  input wire logic timer1_request_flag_in,
  input wire logic skip_next_out,
  input wire logic clear_serial_request_out,
  input wire logic clear_timer1_request_out,
  input wire logic test_done_out,
  input wire logic test_skipped_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_take(op);
    exec_valid_in && !skip_next_out && opcode_in == op;
  endsequence
  property p_irq;
    s_take(SKFT_OP_TEST_EXT_IRQ1_LEVEL)
      |=> skip_next_out == ($past(ext_irq1_pin_in) == $past(ext_irq1_control_reg_in[2]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq1 level skip wrong");
  property p_pd;
    s_take(SKFT_OP_TEST_POWER_DOWN_FLAG)
      |=> skip_next_out == $past(power_down_flag_in) && !clear_serial_request_out
        && !clear_timer1_request_out;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down skip wrong");
  property p_ser;
    s_take(SKFT_OP_TEST_SERIAL_REQUEST) |=> skip_next_out == clear_serial_request_out
      && skip_next_out == ($past(serial_request_flag_in) && !$past(periph_irq_control_reg_b_in[3]));
  endproperty
  a_ser: assert property (p_ser) else $error("serial skip wrong");
  property p_tmr;
    s_take(SKFT_OP_TEST_TIMER1_REQUEST) |=> skip_next_out == clear_timer1_request_out
      && skip_next_out == ($past(timer1_request_flag_in) && !$past(periph_irq_control_reg_a_in[2]));
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer1 skip wrong");
  property p_drop;
    skip_next_out && exec_valid_in |=> !skip_next_out && !test_done_out;
  endproperty
  a_drop: assert property (p_drop) else $error("discarded slot acted");
  property p_done;
    s_take(SKFT_OP_TEST_POWER_DOWN_FLAG) |=> test_done_out && test_skipped_out == skip_next_out;
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_pulse;
    clear_timer1_request_out |=> !clear_timer1_request_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clear pulse too long");
  property p_idle;
    !exec_valid_in && !skip_next_out |=> !test_done_out && !skip_next_out;
  endproperty
  a_idle: assert property (p_idle) else $error("action without a test");
endmodule // skft_sva

bind skft_skip_test_unit skft_sva skft_sva_i (.*);

// ==== tb/skft_skip_test_unit_tb.sv ====
// bench for the skip test unit: instruction slots with expected results
// assumes the checker is bound in by its own file
module skft_skip_test_unit_tb
  import skft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, resetn_in, exec_valid_in, ext_irq1_pin_in, power_down_flag_in;
  logic serial_request_flag_in, timer1_request_flag_in, set_s, set_t;
  logic [9:0] opcode_in;
  logic [3:0] ext_irq1_control_reg_in, periph_irq_control_reg_a_in, periph_irq_control_reg_b_in;
  logic skip_next_out, clear_serial_request_out, clear_timer1_request_out;
  logic test_done_out, test_skipped_out;
  int checks, miscompares;
  skft_skip_test_unit skft_skip_test_unit_i (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .exec_valid_in(exec_valid_in),
    .opcode_in(opcode_in),
    .ext_irq1_pin_in(ext_irq1_pin_in),
    .ext_irq1_control_reg_in(ext_irq1_control_reg_in),
    .periph_irq_control_reg_a_in(periph_irq_control_reg_a_in),
    .periph_irq_control_reg_b_in(periph_irq_control_reg_b_in),
    .power_down_flag_in(power_down_flag_in),
    .serial_request_flag_in(serial_request_flag_in),
    .timer1_request_flag_in(timer1_request_flag_in),
    .skip_next_out(skip_next_out),
    .clear_serial_request_out(clear_serial_request_out),
    .clear_timer1_request_out(clear_timer1_request_out),
    .test_done_out(test_done_out),
    .test_skipped_out(test_skipped_out)
  );
  skft_flag_model ser_i (.clk_in(clk_in), .resetn_in(resetn_in), .set_in(set_s),
    .clear_in(clear_serial_request_out), .flag_out(serial_request_flag_in));
  skft_flag_model tmr_i (.clk_in(clk_in), .resetn_in(resetn_in), .set_in(set_t),
    .clear_in(clear_timer1_request_out), .flag_out(timer1_request_flag_in));
  // ****************************************
  // tasks
  // ****************************************
  task chk(input string nm, input logic s, input logic e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %b saw %b", nm, e, s);
    end
  endtask
  // a skipping test is followed at once by a slot that would skip too
  task exe(input logic [9:0] op, input logic sk, input logic cs, input logic ct);
    @(negedge clk_in);
    exec_valid_in = 1'b1;
    opcode_in = op;
    @(negedge clk_in);
    exec_valid_in = sk;
    opcode_in = SKFT_OP_TEST_POWER_DOWN_FLAG;
    chk("done", test_done_out, 1'b1);
    chk("skip", skip_next_out, sk);
    chk("skipped", test_skipped_out, sk);
    chk("clr_s", clear_serial_request_out, cs);
    chk("clr_t", clear_timer1_request_out, ct);
    if (sk)
    begin
      @(negedge clk_in);
      exec_valid_in = 1'b0;
      chk("drop", skip_next_out | test_done_out, 1'b0);
    end
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial
  begin
    #(25 * 2000);
    miscompares++;
    close_out;
  end
  initial
  begin
    {exec_valid_in, ext_irq1_pin_in, set_s, set_t, resetn_in} = 5'h00;
    power_down_flag_in = 1'b1;
    opcode_in = 10'h000;
    ext_irq1_control_reg_in = 4'h0;
    periph_irq_control_reg_a_in = 4'h0;
    periph_irq_control_reg_b_in = 4'h0;
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ext_irq1_control_reg_in = i[1] ? 4'h4 : 4'hb;
      ext_irq1_pin_in = i[0];
      exe(SKFT_OP_TEST_EXT_IRQ1_LEVEL, i[0] == i[1], 1'b0, 1'b0);
    end
    power_down_flag_in = 1'b0;
    exe(SKFT_OP_TEST_POWER_DOWN_FLAG, 1'b0, 1'b0, 1'b0);
    power_down_flag_in = 1'b1;
    exe(SKFT_OP_TEST_POWER_DOWN_FLAG, 1'b1, 1'b0, 1'b0);
    // a word outside the group must neither pulse nor skip
    @(negedge clk_in);
    exec_valid_in = 1'b1;
    opcode_in = 10'h281;
    @(negedge clk_in);
    exec_valid_in = 1'b0;
    chk("none_done", test_done_out, 1'b0);
    chk("none_skip", skip_next_out, 1'b0);
    // reset in mid-run while a discard is pending
    @(negedge clk_in);
    exec_valid_in = 1'b1;
    opcode_in = SKFT_OP_TEST_POWER_DOWN_FLAG;
    @(negedge clk_in);
    exec_valid_in = 1'b0;
    chk("pend_skip", skip_next_out, 1'b1);
    resetn_in = 1'b0;
    #1;
    chk("rst_skip", skip_next_out, 1'b0);
    chk("rst_done", test_done_out, 1'b0);
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    for (int e = 0; e < 2; e++)
    begin
      periph_irq_control_reg_b_in = e[0] ? 4'h8 : 4'h7;
      periph_irq_control_reg_a_in = e[0] ? 4'h4 : 4'hb;
      {set_s, set_t} = 2'h3;
      @(negedge clk_in);
      {set_s, set_t} = 2'h0;
      exe(SKFT_OP_TEST_SERIAL_REQUEST, !e[0], !e[0], 1'b0);
      exe(SKFT_OP_TEST_TIMER1_REQUEST, !e[0], 1'b0, !e[0]);
      chk("ser_flag", serial_request_flag_in, e[0]);
      chk("tmr_flag", timer1_request_flag_in, e[0]);
      exe(SKFT_OP_TEST_SERIAL_REQUEST, 1'b0, 1'b0, 1'b0);
    end
    close_out;
  end
endmodule // skft_skip_test_unit_tb
